//--- hw/wdt_consts.vh
// Purpose: Shared constants for the eight-bit watchdog timer
// Assumes: APB byte addresses, 32-bit data, 20 MHz pclk
// Notes: Definitions only
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ==========================================================
// Register byte addresses
`define WDT_ADDR_CTRL 8'h00
`define WDT_ADDR_COUNT 8'h04
`define WDT_ADDR_MODE 8'h08
`define WDT_ADDR_IRQ_STAT 8'h0c
`define WDT_ADDR_IRQ_MASK 8'h10

// ==========================================================
// Control/status field positions
`define WDT_B_CNT_INH 7
`define WDT_B_CNT_WE 6
`define WDT_B_CTL_INH 5
`define WDT_B_CTL_WE 4
`define WDT_B_RUN_INH 3
`define WDT_B_RUN 2
`define WDT_B_FLAG_INH 1
`define WDT_B_FLAG 0

// Mode register fields
`define WDT_M_CKSEL 0
`define WDT_M_LSB 1
`define WDT_M_MSB 3

// Power modes
`define WDT_PM_ACTIVE 3'h0
`define WDT_PM_SLEEP 3'h1
`define WDT_PM_SUBACT 3'h4

// ==========================================================
// Counts and reset values
`define WDT_SYS_DIV 8192
`define WDT_SUB_DIV 32
`define WDT_RST_CYC 512
`define WDT_COUNT_RST 8'h00
`define WDT_COUNT_TOP 8'hff
`define WDT_INH_MASK 8'haa

`endif

//--- hw/wdt_sync.v
// Purpose: Two-flop synchroniser for an asynchronous level
// Assumes: Destination clock pclk
// Notes: First flop is read only by the second
`default_nettype none

module wdt_sync (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Data
    input wire async_in,
    output wire sync_out
);

reg meta_q;
reg sync_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
    end else begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

assign sync_out = sync_q;

endmodule // wdt_sync
`default_nettype wire

//--- hw/wdt_tick.v
// Purpose: Count-enable pulse from the selected prescaled source
// Assumes: Subclock already synchronised to pclk
// Notes: Pulse is one pclk wide; prescalers run while clken is high
`default_nettype none
`include "wdt_consts.vh"

module wdt_tick #(
    parameter SYS_DIV = `WDT_SYS_DIV,
    parameter SUB_DIV = `WDT_SUB_DIV
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire clken,
    // Sources
    input wire sub_clk_sync,
    input wire clk_sel,
    // Output
    output wire tick
);

reg [12:0] sys_cnt_q;
reg [4:0] sub_cnt_q;
reg sub_prev_q;
reg tick_q;
wire sub_rise;
wire sys_wrap;
wire sub_wrap;

assign sub_rise = sub_clk_sync & ~sub_prev_q;
assign sys_wrap = (sys_cnt_q == SYS_DIV - 1);
assign sub_wrap = sub_rise & (sub_cnt_q == SUB_DIV - 1);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sys_cnt_q <= 13'h0000;
        sub_cnt_q <= 5'h00;
        sub_prev_q <= 1'b0;
        tick_q <= 1'b0;
    end else if (clken) begin
        sub_prev_q <= sub_clk_sync;
        sys_cnt_q <= sys_wrap ? 13'h0000 : sys_cnt_q + 13'h0001;
        if (sub_rise)
            sub_cnt_q <= sub_wrap ? 5'h00 : sub_cnt_q + 5'h01;
        // Single-cycle enable in the pclk domain
        tick_q <= clk_sel ? sub_wrap : sys_wrap;
    end
end

assign tick = tick_q;

endmodule // wdt_tick
`default_nettype wire

//--- hw/wdt_top.v
// Purpose: Eight-bit watchdog timer with APB register access
// Assumes: pclk 20 MHz; sub_clk is an asynchronous slow clock pin
// Notes: Chip reset pulse is long enough to cover the oscillator count
`default_nettype none
`include "wdt_consts.vh"

module wdt_top #(
    parameter RST_CYC = `WDT_RST_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire clken,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Subclock pin
    input wire sub_clk,
    // Outputs
    output wire chip_reset,
    output wire irq
);

// ==========================================================
// Registers
reg [7:0] watchdog_count_q;
reg count_write_enable_q;
reg ctrl_write_enable_q;
reg watchdog_run_q;
reg watchdog_reset_flag_q;
reg watchdog_clock_select_q;
reg [2:0] power_mode_q;
reg [1:0] irq_stat_q;
reg [1:0] irq_mask_q;
reg [9:0] rst_cnt_q;
reg [31:0] prdata_q;

wire sub_clk_sync;
wire tick;
wire wr;
wire rd;
wire [7:0] wd;
wire cnt_mode_ok;
wire ctrl_mode_ok;
wire step;
wire overflow;
wire ctl_wr;
wire cnt_wr;
wire [9:0] rst_last;
wire [31:0] rst_last_full;

assign wr = psel & penable & pwrite;
assign rd = psel & ~penable & ~pwrite;
assign wd = pwdata[7:0];
// Pulse counter is ten bits wide; the length must fit in it
assign rst_last_full = RST_CYC - 1;
assign rst_last = rst_last_full[9:0];

// ==========================================================
// Subclock path
wdt_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sub_clk),
    .sync_out(sub_clk_sync)
);

wdt_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clken(clken),
    .sub_clk_sync(sub_clk_sync),
    .clk_sel(watchdog_clock_select_q),
    .tick(tick)
);

// ==========================================================
// Power-mode gating
// Active and sleep always run; sub-active only on the subclock source
assign cnt_mode_ok = (power_mode_q == `WDT_PM_ACTIVE) |
                     (power_mode_q == `WDT_PM_SLEEP) |
                     ((power_mode_q == `WDT_PM_SUBACT) &
                      watchdog_clock_select_q);
assign ctrl_mode_ok = cnt_mode_ok;
assign ctl_wr = wr & (paddr == `WDT_ADDR_CTRL) & ctrl_mode_ok;
assign cnt_wr = wr & (paddr == `WDT_ADDR_COUNT) & ctrl_mode_ok &
                count_write_enable_q;
assign step = tick & watchdog_run_q & cnt_mode_ok;
assign overflow = step & ~cnt_wr &
                  (watchdog_count_q == `WDT_COUNT_TOP);

// ==========================================================
// Counter
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        watchdog_count_q <= `WDT_COUNT_RST;
    end else if (clken) begin
        if (cnt_wr)
            watchdog_count_q <= wd;
        else if (step)
            watchdog_count_q <= watchdog_count_q + 8'h01;
    end
end

// ==========================================================
// Control/status register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_write_enable_q <= 1'b0;
        ctrl_write_enable_q <= 1'b0;
        watchdog_run_q <= 1'b0;
        watchdog_reset_flag_q <= 1'b0;
    end else if (clken) begin
        if (ctl_wr && !wd[`WDT_B_CNT_INH])
            count_write_enable_q <= wd[`WDT_B_CNT_WE];
        if (ctl_wr && !wd[`WDT_B_CTL_INH])
            ctrl_write_enable_q <= wd[`WDT_B_CTL_WE];
        // Run and flag use the enable as it stood before this write
        if (ctl_wr && ctrl_write_enable_q && !wd[`WDT_B_RUN_INH])
            watchdog_run_q <= wd[`WDT_B_RUN];
        if (overflow)
            watchdog_reset_flag_q <= 1'b1;
        else if (ctl_wr && ctrl_write_enable_q &&
                 !wd[`WDT_B_FLAG_INH] && !wd[`WDT_B_FLAG])
            watchdog_reset_flag_q <= 1'b0;
    end
end

// ==========================================================
// Mode register: clock select and power mode
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        watchdog_clock_select_q <= 1'b0;
        power_mode_q <= `WDT_PM_ACTIVE;
    end else if (clken && wr && paddr == `WDT_ADDR_MODE) begin
        watchdog_clock_select_q <= pwdata[`WDT_M_CKSEL];
        power_mode_q <= pwdata[`WDT_M_MSB:`WDT_M_LSB];
    end
end

// ==========================================================
// Internal reset pulse
// Oscillator cycles are taken as pclk cycles
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rst_cnt_q <= 10'h000;
    end else if (clken) begin
        if (overflow)
            rst_cnt_q <= rst_last + 10'h001;
        else if (rst_cnt_q != 10'h000)
            rst_cnt_q <= rst_cnt_q - 10'h001;
    end
end

assign chip_reset = (rst_cnt_q != 10'h000);

// ==========================================================
// Interrupts: bit0 overflow, bit1 reset pulse ended; write one clears
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_stat_q <= 2'h0;
        irq_mask_q <= 2'h0;
    end else if (clken) begin
        // Set wins over a clear in the same cycle
        irq_stat_q[0] <= overflow |
            (irq_stat_q[0] &
             ~(wr && paddr == `WDT_ADDR_IRQ_STAT && pwdata[0]));
        irq_stat_q[1] <= (rst_cnt_q == 10'h001) |
            (irq_stat_q[1] &
             ~(wr && paddr == `WDT_ADDR_IRQ_STAT && pwdata[1]));
        if (wr && paddr == `WDT_ADDR_IRQ_MASK)
            irq_mask_q <= pwdata[1:0];
    end
end

assign irq = |(irq_stat_q & irq_mask_q);

// ==========================================================
// Read path
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_q <= 32'h00000000;
    end else if (clken && rd) begin
        case (paddr)
            `WDT_ADDR_CTRL:
                prdata_q <= {24'h000000, (`WDT_INH_MASK |
                    {1'b0, count_write_enable_q, 1'b0,
                     ctrl_write_enable_q, 1'b0, watchdog_run_q,
                     1'b0, watchdog_reset_flag_q})};
            `WDT_ADDR_COUNT:
                prdata_q <= {24'h000000, watchdog_count_q};
            `WDT_ADDR_MODE:
                prdata_q <= {28'h0000000, power_mode_q,
                             watchdog_clock_select_q};
            `WDT_ADDR_IRQ_STAT:
                prdata_q <= {30'h00000000, irq_stat_q};
            `WDT_ADDR_IRQ_MASK:
                prdata_q <= {30'h00000000, irq_mask_q};
            default:
                prdata_q <= 32'h00000000;
        endcase
    end
end

assign prdata = prdata_q;
assign pready = 1'b1;
assign pslverr = 1'b0;

endmodule // wdt_top
`default_nettype wire

//--- tb/wdt_sva.sv
// Purpose: Port-level checks for the watchdog top
// Assumes: One pclk domain, presetn async active low
// Notes: Sees only top ports; bound below
`default_nettype none

module wdt_sva #(
    parameter RST_CYC = 512
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clken,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Outputs
    input wire logic chip_reset,
    input wire logic irq
);
    // ==========================================
    // Reset pulse length
    logic [15:0] rcnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rcnt_q <= 16'h0;
        else rcnt_q <= chip_reset ? rcnt_q + 16'h1 : 16'h0;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // Assertions
    AST_PREADY: assert property (psel |-> pready)
        else $error("pready low in transfer");
    AST_NO_ERR: assert property (psel && penable |-> !pslverr)
        else $error("pslverr raised");
    // Read data may only move after a read setup edge
    AST_RD_HOLD: assert property (!(psel && !penable && !pwrite)
        |=> $stable(prdata)) else $error("prdata moved");
    AST_UNMAPPED: assert property (psel && !penable && !pwrite
        && clken && paddr == 8'h14 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_INH_ONES: assert property (psel && !penable && !pwrite
        && clken && paddr == 8'h00 |=> (prdata & 32'haa) == 32'haa)
        else $error("inhibit bits not one");
    AST_HI_ZERO: assert property (psel && penable
        |-> prdata[31:8] == 24'h0) else $error("upper data bits set");
    AST_RST_MAX: assert property (rcnt_q <= RST_CYC)
        else $error("chip reset too long");
    AST_RST_LEN: assert property ($fell(chip_reset)
        |-> rcnt_q == RST_CYC) else $error("chip reset too short");
    AST_RST_ZERO: assert property ($rose(presetn)
        |-> !chip_reset && !irq) else $error("outputs not idle at reset");
endmodule // wdt_sva

bind wdt_top wdt_sva #(.RST_CYC(RST_CYC)) u_wdt_sva (
    .pclk(pclk), .presetn(presetn), .clken(clken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_reset(chip_reset),
    .irq(irq)
);
`default_nettype wire

//--- tb/wdt_tb.sv
// Purpose: Self-checking bench for the watchdog top
// Assumes: Subclock source in the mode loop; one system/8192 overflow run last
// Notes: Reads queue expectations, a monitor compares them
`default_nettype none
`include "wdt_consts.vh"
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
    error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, a); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, clken, psel, penable, pwrite, sub_clk;
    logic [7:0] paddr;
    logic [31:0] pwdata, r, e;
    wire [31:0] prdata;
    wire pready, pslverr, chip_reset, irq;
    int error_cnt, n_compared, cyc, seed, i;
    logic [31:0] exq[$];
    logic [31:0] mods[3] = '{32'h01, 32'h03, 32'h09};

    wdt_top #(.RST_CYC(8)) DUT (
        .pclk(pclk), .presetn(presetn), .clken(clken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sub_clk(sub_clk), .chip_reset(chip_reset),
        .irq(irq)
    );

    // ==========================================
    // Clocks, timeout, monitor
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    // Subclock phase unrelated to pclk, well under pclk/2
    initial begin
        sub_clk = 1'h0;
        forever #110 sub_clk = ~sub_clk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            e = exq.pop_front();
            `CHK("prdata", e, prdata)
        end
    end

    // ==========================================
    // Tasks
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        exq.push_back(x);
        apb(1'h0, a, 32'h0);
    endtask
    task ck_irq(input logic x);
        @(negedge pclk);
        `CHK("irq", x, irq)
    endtask
    task ovf(input int lim);
        for (i = 0; i < lim && chip_reset !== 1'h1; i++) @(posedge pclk);
        `CHK("chip_reset", 1'h1, chip_reset)
        while (chip_reset) @(posedge pclk);
    endtask
    task finish_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        seed = 76;
        presetn = 1'h0;
        clken = 1'h1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rd(`WDT_ADDR_CTRL, 32'haa);
        rd(`WDT_ADDR_COUNT, 32'h0);
        apb(1'h1, 8'h14, 32'hff);
        rd(8'h14, 32'h0);
        apb(1'h1, `WDT_ADDR_COUNT, 32'h55);
        rd(`WDT_ADDR_COUNT, 32'h0);
        // Run request without control enable must be dropped
        apb(1'h1, `WDT_ADDR_CTRL, 32'h44);
        rd(`WDT_ADDR_CTRL, 32'hea);
        r = $random(seed) & 32'hff;
        apb(1'h1, `WDT_ADDR_COUNT, r);
        rd(`WDT_ADDR_COUNT, r);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd0);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd4);
        rd(`WDT_ADDR_CTRL, 32'hfe);
        for (int k = 0; k < 3; k++) begin
            apb(1'h1, `WDT_ADDR_MODE, mods[k]);
            apb(1'h1, `WDT_ADDR_COUNT, 32'hfe);
            ovf(1000);
            rd(`WDT_ADDR_COUNT, 32'h0);
        end
        rd(`WDT_ADDR_CTRL, 32'hff);
        rd(`WDT_ADDR_IRQ_STAT, 32'h3);
        ck_irq(1'h0);
        apb(1'h1, `WDT_ADDR_IRQ_MASK, 32'h1);
        ck_irq(1'h1);
        apb(1'h1, `WDT_ADDR_IRQ_STAT, 32'h1);
        ck_irq(1'h0);
        rd(`WDT_ADDR_IRQ_STAT, 32'h2);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd0);
        rd(`WDT_ADDR_CTRL, 32'hfa);
        apb(1'h1, `WDT_ADDR_COUNT, 32'h33);
        repeat (300) @(posedge pclk);
        rd(`WDT_ADDR_COUNT, 32'h33);
        apb(1'h1, `WDT_ADDR_MODE, 32'h05);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd4);
        apb(1'h1, `WDT_ADDR_COUNT, 32'h44);
        rd(`WDT_ADDR_CTRL, 32'hfa);
        rd(`WDT_ADDR_COUNT, 32'h33);
        apb(1'h1, `WDT_ADDR_MODE, 32'h08);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd4);
        rd(`WDT_ADDR_CTRL, 32'hfa);
        // System clock source: one tick of the long prescaler overflows
        apb(1'h1, `WDT_ADDR_MODE, 32'h00);
        apb(1'h1, `WDT_ADDR_CTRL, 32'hd4);
        apb(1'h1, `WDT_ADDR_COUNT, 32'hff);
        ovf(9000);
        rd(`WDT_ADDR_COUNT, 32'h0);
        rd(`WDT_ADDR_CTRL, 32'hff);
        repeat (4) @(posedge pclk);
        finish_test();
    end
endmodule // tb
`default_nettype wire
